/* File: src/sec_consts.svh */
// Constants of the serial EEPROM command and protection block.
// Assumes it is included by bare name from the package and the design file.
`ifndef SEC_CONSTS_SVH
`define SEC_CONSTS_SVH

`define SEC_OP_MASK 8'hf7
`define SEC_OP_SET_WEL 8'h06
`define SEC_OP_CLEAR_WEL 8'h04
`define SEC_OP_FETCH_STATE 8'h05
`define SEC_OP_STORE_STATE 8'h01
`define SEC_OP_READ 8'h03
`define SEC_OP_WRITE 8'h02

`define SEC_ST_BUSY 0
`define SEC_ST_WEL 1
`define SEC_ST_GUARD_LO 2
`define SEC_ST_GUARD_HI 3
`define SEC_ST_PIN_LOCK 7
`define SEC_ST_ALL_ONES 8'hff

`define SEC_ARRAY_AW 13
`define SEC_PAGE_AW 5
`define SEC_PAGE_BYTES 32
`define SEC_FIFO_DEPTH 4
`define SEC_FIFO_W 21

`define SEC_CLK_KHZ 25000
`define SEC_T_WC_MS 5
`define SEC_T_WC_CYC (`SEC_T_WC_MS * `SEC_CLK_KHZ)
`define SEC_TIMER_W 17

`endif

/* File: src/sec_eeprom_ctrl.sv */
// Command decoder, status register and write protection of an SPI serial EEPROM, plus its write FIFO.
// Assumes every SPI pin is asynchronous to clk and that the array answers memRdAddr within one clk.
//
// Overview of operation
// - Selection starts a transaction; everything shifts eight bits, MSB first.
// - Opcode 0000x110 sets the write latch, 0000x100 clears it.
// - Opcode 0000x101 reads status, 0000x001 writes status.
// - Opcode 0000x011 reads the array, 0000x010 writes it.
// - Write latch is clear after reset; it must be set before programming.
// - Clearing the latch stops all programming regardless of the guard pin.
// - Status bit 1 shows the write latch.
// - Status bit 0 shows a running write cycle.
// - Bits 4 to 6 read zero when ready, and the whole byte reads all ones during a write cycle; bit 7 is pin lock, bits 3:2 guard.
// - Guard 00 none, 01 top quarter, 10 top half, 11 whole array.
// - Guard and pin lock bits change only after a full write cycle.
// - Guard pin low with pin lock set rejects every status write.
// - Pin lock stays set while hardware protection holds.
// - Guarded addresses never program; others only with the latch set.
// - Read: opcode, 16-bit address, then data out MSB first.
// - Reads advance the address per byte and wrap to zero.
// - During a write cycle only the status read is accepted.
// - Write: opcode, address, data; deselect after a whole byte starts programming.
// - Page writes step the low five address bits only and wrap.
// - Completion of a write cycle clears the write latch.
// - A write without the latch is dropped at deselect.
// - Unknown opcodes leave the device quiet until next selection.
// - Deselected, input is ignored and the output floats.
// - Hold low during clock low pauses the sequence; high resumes it.
`timescale 1ns/1ns
`include "sec_consts.svh"

module sec_fifo #(
   parameter int WIDTH = `SEC_FIFO_W,
   parameter int DEPTH = `SEC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wrPtr;
      logic [PW-1:0] rdPtr;
      logic [PW:0] count;
   } sec_fifo_st_t;

   sec_fifo_st_t q, d;
   logic push;
   logic pop;

   assign inReady = (q.count != (PW+1)'(DEPTH));
   assign outValid = (q.count != '0);
   assign outData = q.mem[q.rdPtr];
   assign push = inValid & inReady;
   assign pop = outValid & outReady;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wrPtr] = inData;
         d.wrPtr = (q.wrPtr == PW'(DEPTH - 1)) ? '0 : q.wrPtr + PW'(1);
      end
      if (pop) begin
         d.rdPtr = (q.rdPtr == PW'(DEPTH - 1)) ? '0 : q.rdPtr + PW'(1);
      end
      d.count = q.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // sec_fifo

module sec_eeprom_ctrl #(
   parameter logic [`SEC_TIMER_W-1:0] WRITE_CYCLE_CYC = `SEC_TIMER_W'(`SEC_T_WC_CYC)
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic sck,
   input wire logic si,
   input wire logic wp_b,
   input wire logic hold_b,
   output logic soOut,
   output logic soOe_b,
   output logic [`SEC_ARRAY_AW-1:0] memRdAddr,
   input wire logic [7:0] memRdData,
   output logic memWrValid,
   input wire logic memWrReady,
   output logic [`SEC_ARRAY_AW-1:0] memWrAddr,
   output logic [7:0] memWrData
);
   sec_pkg::sec_core_t q, d;
   logic sckRise;
   logic sckFall;
   logic csRise;
   logic byteDone;
   logic hwProt;
   logic [7:0] inByte;
   logic [7:0] statusByte;
   logic [7:0] loadByte;
   logic drainValid;
   logic drainReady;
   logic drainPush;
   logic [`SEC_FIFO_W-1:0] drainWord;
   logic [`SEC_FIFO_W-1:0] memWord;

   function automatic logic sec_op_is(input logic [7:0] op, input logic [7:0] code);
      return (op & `SEC_OP_MASK) == code;
   endfunction

   // The array is sized for the largest member, so the guarded regions are fixed fractions of 8K.
   function automatic logic sec_guarded(input logic [`SEC_ARRAY_AW-1:0] a, input logic [1:0] g);
      logic hit;
      hit = 1'b0;
      unique case (g)
         2'b00: hit = 1'b0;
         2'b01: hit = (a[`SEC_ARRAY_AW-1:`SEC_ARRAY_AW-2] == 2'b11);
         2'b10: hit = a[`SEC_ARRAY_AW-1];
         2'b11: hit = 1'b1;
      endcase
      return hit;
   endfunction

   // Edges are only honoured while selected and not paused by the hold pin.
   assign sckRise = q.sckS2 & ~q.sckPrev & q.selS2 & ~q.paused;
   assign sckFall = ~q.sckS2 & q.sckPrev & q.selS2 & ~q.paused;
   assign csRise = ~q.selS2 & q.selPrev;
   assign inByte = {q.shift[6:0], q.siS2};
   assign byteDone = sckRise & (q.bitCnt == 3'h7);
   assign hwProt = q.wpLowS2 & q.pinLock;
   assign statusByte = q.busy ? `SEC_ST_ALL_ONES : {q.pinLock, 3'h0, q.guard, q.wel, 1'b0};
   assign loadByte = (q.state == sec_pkg::SEC_RD_DATA) ? memRdData : statusByte;
   assign drainValid = q.draining & q.pageMask[q.drainIdx];
   assign drainPush = drainValid & drainReady;
   assign drainWord = {q.pageBase, q.drainIdx, q.pageBuf[q.drainIdx]};

   assign soOut = q.soBit;
   assign soOe_b = ~(q.soDrive & q.selS2 & ~q.paused);
   assign memRdAddr = q.rdAddr;
   assign memWrAddr = memWord[`SEC_FIFO_W-1:8];
   assign memWrData = memWord[7:0];

   always_comb begin
      d = q;
      d.selS1 = ~cs_b;
      d.selS2 = q.selS1;
      d.selPrev = q.selS2;
      d.sckS1 = sck;
      d.sckS2 = q.sckS1;
      d.sckPrev = q.sckS2;
      d.siS1 = si;
      d.siS2 = q.siS1;
      d.wpLowS1 = ~wp_b;
      d.wpLowS2 = q.wpLowS1;
      d.holdLowS1 = ~hold_b;
      d.holdLowS2 = q.holdLowS1;

      if (!q.selS2) begin
         d.paused = 1'b0;
      end else if (!q.sckS2) begin
         d.paused = q.holdLowS2;
      end

      if (!q.selS2) begin
         // Deselect returns to opcode reception, so the next selection restarts cleanly.
         d.state = sec_pkg::SEC_IDLE;
         d.bitCnt = 3'h0;
         d.soDrive = 1'b0;
         d.statGot = 1'b0;
         d.atBoundary = 1'b0;
         if (csRise && q.atBoundary && q.wel) begin
            if (q.state == sec_pkg::SEC_WR_DATA && q.pageMask != '0) begin
               d.busy = 1'b1;
               d.draining = 1'b1;
               d.drainIdx = '0;
               d.timer = WRITE_CYCLE_CYC;
            end else if (q.state == sec_pkg::SEC_STAT_WR && q.statGot && !hwProt) begin
               d.busy = 1'b1;
               d.statPend = 1'b1;
               d.timer = WRITE_CYCLE_CYC;
            end
         end
      end

      if (sckRise) begin
         d.shift = inByte;
         d.bitCnt = q.bitCnt + 3'h1;
         d.atBoundary = 1'b0;
         if (byteDone) begin
            d.atBoundary = 1'b1;
            unique case (q.state)
               sec_pkg::SEC_IDLE: begin
                  if (q.busy && !sec_op_is(inByte, `SEC_OP_FETCH_STATE)) begin
                     d.state = sec_pkg::SEC_QUIET;
                  end else if (sec_op_is(inByte, `SEC_OP_SET_WEL)) begin
                     d.wel = 1'b1;
                     d.state = sec_pkg::SEC_QUIET;
                  end else if (sec_op_is(inByte, `SEC_OP_CLEAR_WEL)) begin
                     d.wel = 1'b0;
                     d.state = sec_pkg::SEC_QUIET;
                  end else if (sec_op_is(inByte, `SEC_OP_FETCH_STATE)) begin
                     d.state = sec_pkg::SEC_STAT_RD;
                  end else if (sec_op_is(inByte, `SEC_OP_STORE_STATE)) begin
                     d.state = sec_pkg::SEC_STAT_WR;
                  end else if (sec_op_is(inByte, `SEC_OP_READ)) begin
                     d.isWrite = 1'b0;
                     d.state = sec_pkg::SEC_ADDR_HI;
                  end else if (sec_op_is(inByte, `SEC_OP_WRITE)) begin
                     d.isWrite = 1'b1;
                     d.state = sec_pkg::SEC_ADDR_HI;
                  end else begin
                     d.state = sec_pkg::SEC_QUIET;
                  end
               end
               sec_pkg::SEC_ADDR_HI: begin
                  d.addr[15:8] = inByte;
                  d.state = sec_pkg::SEC_ADDR_LO;
               end
               sec_pkg::SEC_ADDR_LO: begin
                  d.addr[7:0] = inByte;
                  // The upper address bits beyond the array are dropped here.
                  d.rdAddr = {q.addr[`SEC_ARRAY_AW-1:8], inByte};
                  d.pageMask = '0;
                  d.state = q.isWrite ? sec_pkg::SEC_WR_DATA : sec_pkg::SEC_RD_DATA;
               end
               sec_pkg::SEC_WR_DATA: begin
                  if (q.wel && !sec_guarded(q.addr[`SEC_ARRAY_AW-1:0], q.guard)) begin
                     d.pageBuf[q.addr[`SEC_PAGE_AW-1:0]] = inByte;
                     d.pageMask[q.addr[`SEC_PAGE_AW-1:0]] = 1'b1;
                  end
                  d.pageBase = q.addr[`SEC_ARRAY_AW-1:`SEC_PAGE_AW];
                  d.addr[`SEC_PAGE_AW-1:0] = q.addr[`SEC_PAGE_AW-1:0] + 5'h01;
               end
               sec_pkg::SEC_STAT_WR: begin
                  d.pendStat = inByte;
                  d.statGot = 1'b1;
               end
               default: begin
               end
            endcase
         end
      end

      if (sckFall && (q.state == sec_pkg::SEC_RD_DATA || q.state == sec_pkg::SEC_STAT_RD)) begin
         if (q.bitCnt == 3'h0) begin
            d.soBit = loadByte[7];
            d.outShift = {loadByte[6:0], 1'b0};
            d.soDrive = 1'b1;
            if (q.state == sec_pkg::SEC_RD_DATA) begin
               d.rdAddr = q.rdAddr + 13'h0001;
            end
         end else begin
            d.soBit = q.outShift[7];
            d.outShift = {q.outShift[6:0], 1'b0};
         end
      end

      if (q.draining && (!q.pageMask[q.drainIdx] || drainReady)) begin
         d.pageMask[q.drainIdx] = 1'b0;
         d.drainIdx = q.drainIdx + 5'h01;
         if (q.drainIdx == 5'h1f) begin
            d.draining = 1'b0;
         end
      end

      if (q.busy && q.timer != '0) begin
         d.timer = q.timer - 17'h00001;
      end

      // The cycle ends only after the timer and the array have both finished.
      if (q.busy && !q.draining && q.timer == '0 && !memWrValid) begin
         d.busy = 1'b0;
         d.wel = 1'b0;
         if (q.statPend) begin
            d.statPend = 1'b0;
            d.guard = q.pendStat[`SEC_ST_GUARD_HI:`SEC_ST_GUARD_LO];
            d.pinLock = q.pendStat[`SEC_ST_PIN_LOCK];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   sec_fifo #(
      .WIDTH(`SEC_FIFO_W),
      .DEPTH(`SEC_FIFO_DEPTH)
   ) u_wr_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .inValid(drainValid),
      .inReady(drainReady),
      .inData(drainWord),
      .outValid(memWrValid),
      .outReady(memWrReady),
      .outData(memWord)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence sOpDone;
      byteDone && q.state == sec_pkg::SEC_IDLE;
   endsequence

   // Latch opcodes are judged only when idle, since a running cycle quietens every opcode but the status read.
   sequence sOpIdle;
      sOpDone ##0 !q.busy;
   endsequence

   sequence sOpBusy;
      sOpDone ##0 (q.busy && !sec_op_is(inByte, `SEC_OP_FETCH_STATE));
   endsequence

   sequence sStatLoad;
      sckFall && q.state == sec_pkg::SEC_STAT_RD && q.bitCnt == 3'h0;
   endsequence

   // A hold must freeze the sequence and never count as an extra clock edge.
   sequence sHeld;
      q.paused && q.selS2;
   endsequence

   a_busy_ignores_ops: assert property (sOpBusy |=> q.state == sec_pkg::SEC_QUIET)
      else $error("opcode accepted during write cycle");
   a_set_latch_op: assert property ((sOpIdle ##0 sec_op_is(inByte, `SEC_OP_SET_WEL)) |=> q.wel)
      else $error("write latch not set");
   a_clear_latch_op: assert property ((sOpIdle ##0 sec_op_is(inByte, `SEC_OP_CLEAR_WEL)) |=> !q.wel)
      else $error("write latch not cleared");
   a_latch_needs_set: assert property ($rose(q.wel) |-> $past(byteDone && q.state == sec_pkg::SEC_IDLE))
      else $error("write latch set without opcode");
   a_status_ready_bits: assert property ((sStatLoad ##0 !q.busy) |=>
      (q.outShift[7:5] == 3'h0 && q.outShift[2] == $past(q.wel) && !q.outShift[1] && q.soBit == $past(q.pinLock)))
      else $error("status byte wrong while ready");
   a_status_busy_ones: assert property ((sStatLoad ##0 q.busy) |=>
      ({q.soBit, q.outShift[7:1]} == 8'hff))
      else $error("status not all ones while busy");
   a_wel_auto_clear: assert property ($fell(q.busy) |-> !q.wel)
      else $error("write latch survived write cycle");
   a_cycle_needs_wel: assert property ($rose(q.busy) |-> ($past(q.wel) && $past(csRise)))
      else $error("write cycle without latch or deselect");
   a_guard_never_push: assert property (drainPush |-> !sec_guarded({q.pageBase, q.drainIdx}, q.guard))
      else $error("guarded address programmed");
   a_pin_lock_holds: assert property ((hwProt && !q.statPend) |=> q.pinLock)
      else $error("pin lock dropped under protection");
   a_quiet_output_off: assert property (q.state == sec_pkg::SEC_QUIET |-> soOe_b)
      else $error("output driven after bad opcode");
   a_deselect_float: assert property (!q.selS2 |=> soOe_b)
      else $error("output driven while deselected");
   a_read_wraps_zero: assert property ((sckFall && q.state == sec_pkg::SEC_RD_DATA && q.bitCnt == 3'h0
      && q.rdAddr == 13'h1fff) |=> q.rdAddr == 13'h0000)
      else $error("read address did not wrap");
   a_page_upper_fixed: assert property ((byteDone && q.state == sec_pkg::SEC_WR_DATA) |=>
      (q.addr[15:5] == $past(q.addr[15:5]) && q.addr[4:0] == $past(q.addr[4:0]) + 5'h01))
      else $error("page address stepped wrongly");
   a_hold_freezes_bits: assert property (sHeld |=> $stable(q.bitCnt))
      else $error("bit counter moved during hold");
   a_hold_keeps_data: assert property (sHeld |=> $stable(q.soBit))
      else $error("output bit moved during hold");
   a_prot_blocks_status: assert property ((csRise && hwProt && !q.statPend) |=> !q.statPend)
      else $error("status write accepted under protection");
   a_cut_write_dropped: assert property ((csRise && !q.atBoundary && !q.busy) |=> !q.busy)
      else $error("write cycle after cut byte");
endmodule // sec_eeprom_ctrl

/* File: src/sec_pkg.sv */
// Types of the serial EEPROM command and protection block.
// Assumes sec_consts.svh is on the include path.
`include "sec_consts.svh"

package sec_pkg;

   typedef enum logic [2:0] {
      SEC_IDLE,
      SEC_ADDR_HI,
      SEC_ADDR_LO,
      SEC_RD_DATA,
      SEC_WR_DATA,
      SEC_STAT_RD,
      SEC_STAT_WR,
      SEC_QUIET
   } sec_state_t;

   typedef struct packed {
      logic selS1;
      logic selS2;
      logic selPrev;
      logic sckS1;
      logic sckS2;
      logic sckPrev;
      logic siS1;
      logic siS2;
      logic wpLowS1;
      logic wpLowS2;
      logic holdLowS1;
      logic holdLowS2;
      logic paused;
      sec_state_t state;
      logic [2:0] bitCnt;
      logic [7:0] shift;
      logic [15:0] addr;
      logic isWrite;
      logic atBoundary;
      logic wel;
      logic pinLock;
      logic [1:0] guard;
      logic [7:0] pendStat;
      logic statGot;
      logic statPend;
      logic busy;
      logic [`SEC_TIMER_W-1:0] timer;
      logic [`SEC_PAGE_BYTES-1:0][7:0] pageBuf;
      logic [`SEC_PAGE_BYTES-1:0] pageMask;
      logic [`SEC_ARRAY_AW-`SEC_PAGE_AW-1:0] pageBase;
      logic draining;
      logic [`SEC_PAGE_AW-1:0] drainIdx;
      logic [7:0] outShift;
      logic soBit;
      logic soDrive;
      logic [`SEC_ARRAY_AW-1:0] rdAddr;
   } sec_core_t;

endpackage

/* File: verification/sec_array_model.sv */
// Behavioural array standing behind the controller's write FIFO.
// Assumes the single clk domain; it stalls every other cycle so the FIFO has to hold words.
`timescale 1ns/1ns
`include "sec_consts.svh"
module sec_array_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`SEC_ARRAY_AW-1:0] memRdAddr,
   output logic [7:0] memRdData,
   input wire logic memWrValid,
   output logic memWrReady,
   input wire logic [`SEC_ARRAY_AW-1:0] memWrAddr,
   input wire logic [7:0] memWrData
);
   logic [7:0] mem [0:(1<<`SEC_ARRAY_AW)-1];
   int wrCount;
   logic stallQ;
   // Every cell starts at its own address mixed with a pattern, so a wrong address shows.
   initial begin
      for (int i = 0; i < (1 << `SEC_ARRAY_AW); i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
   end
   assign memRdData = mem[memRdAddr];
   assign memWrReady = stallQ;
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stallQ <= 1'b0;
         wrCount <= 0;
      end else begin
         stallQ <= !stallQ;
         if (memWrValid && memWrReady) begin
            mem[memWrAddr] <= memWrData;
            wrCount <= wrCount + 1;
         end
      end
   end
endmodule // sec_array_model

/* File: verification/sec_eeprom_ctrl_tb.sv */
// Self-checking bench for the EEPROM command and protection controller.
// Assumes the array model and the design files; acts as a mode 0 SPI master with a 320 ns clock.
`timescale 1ns/1ns
`include "sec_consts.svh"
module sec_eeprom_ctrl_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cs_b = 1'b1;
   logic sck = 1'b0;
   logic si = 1'b0;
   logic wp_b = 1'b1;
   logic hold_b = 1'b1;
   logic soOut, soOe_b, memWrValid, memWrReady, oeSeen;
   logic [`SEC_ARRAY_AW-1:0] memRdAddr, memWrAddr;
   logic [7:0] memRdData, memWrData, got, st;
   int failures = 0;
   int samples_checked = 0;
   int n0;
   always #20 clk = ~clk;
   // A short write cycle keeps the run brief but still spans two status reads.
   sec_eeprom_ctrl #(.WRITE_CYCLE_CYC(17'd300)) i_dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck),
      .si(si), .wp_b(wp_b), .hold_b(hold_b), .soOut(soOut), .soOe_b(soOe_b), .memRdAddr(memRdAddr),
      .memRdData(memRdData), .memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr),
      .memWrData(memWrData));
   sec_array_model i_mem (.clk(clk), .rst_b(rst_b), .memRdAddr(memRdAddr), .memRdData(memRdData),
      .memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr), .memWrData(memWrData));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic sel();
      @(posedge clk);
      cs_b <= 1'b0;
      tick(6);
   endtask
   // Chip select rises in the SCK low time right after the last bit, as a write requires.
   task automatic desel();
      @(posedge clk);
      sck <= 1'b0;
      tick(2);
      cs_b <= 1'b1;
      tick(8);
   endtask
   // SO is sampled half a clk after SCK rises, well before the next fall can move it.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb = 8, input int top = 7);
      for (int i = top; i > top - nb; i--) begin
         @(posedge clk);
         sck <= 1'b0;
         si <= tx[i];
         tick(4);
         sck <= 1'b1;
         @(negedge clk);
         // A released SO line is taken as pulled high, so a missing drive shows on any byte except one expected as all ones.
         rx[i] = (soOe_b === 1'b0) ? soOut : 1'b1;
         if (soOe_b === 1'b0) oeSeen = 1'b1;
         tick(3);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      sel();
      xfer(op, got);
      desel();
   endtask
   task automatic rdStat(output logic [7:0] s);
      sel();
      xfer(8'h05, got);
      xfer(8'h00, s);
      desel();
   endtask
   task automatic wrBytes(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d, input int n);
      sel();
      xfer(op, got);
      if (op == 8'h02) begin
         xfer(a[15:8], got);
         xfer(a[7:0], got);
      end
      for (int i = 0; i < n; i++) xfer(d + 8'(i), got);
      desel();
   endtask
   task automatic waitReady();
      st = 8'hff;
      for (int k = 0; k < 10 && st === 8'hff; k++) rdStat(st);
      if (st === 8'hff) begin
         failures++;
         $display("[ERR] %0t busy never ended", $time);
         stop_test();
      end
   endtask
   task automatic t_reset();
      check({7'h00, soOe_b}, 8'h01, "SO released");
      rdStat(st);
      check(st, 8'h00, "status after reset");
      $display("reset test done");
   endtask
   task automatic t_latch();
      logic [7:0] ops [4] = '{8'h06, 8'h04, 8'h0e, 8'h0c};
      logic [7:0] exp [4] = '{8'h02, 8'h00, 8'h02, 8'h00};
      wp_b <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         cmd(ops[i]);
         rdStat(st);
         check(st, exp[i], "latch bit");
      end
      wp_b <= 1'b1;
      $display("latch test done");
   endtask
   task automatic t_noLatch();
      n0 = i_mem.wrCount;
      wrBytes(8'h02, 16'h0100, 8'h99, 1);
      tick(40);
      check(8'(i_mem.wrCount - n0), 8'h00, "write without latch");
      $display("no latch test done");
   endtask
   task automatic t_page();
      cmd(8'h06);
      n0 = i_mem.wrCount;
      wrBytes(8'h02, 16'h003e, 8'ha0, 3);
      rdStat(st);
      check(st, 8'hff, "busy status");
      cmd(8'h06);
      waitReady();
      check(st, 8'h00, "latch after cycle");
      check(i_mem.mem[16'h3e], 8'ha0, "page byte 0");
      check(i_mem.mem[16'h3f], 8'ha1, "page byte 1");
      check(i_mem.mem[16'h20], 8'ha2, "page wrap");
      check(8'(i_mem.wrCount - n0), 8'h03, "stored count");
      $display("page test done");
   endtask
   task automatic t_read();
      sel();
      xfer(8'h03, got);
      xfer(8'hff, got);
      xfer(8'hff, got);
      xfer(8'h00, got);
      check(got, 8'ha5, "read top address");
      xfer(8'h00, got);
      check(got, 8'h5a, "read rollover");
      desel();
      $display("read test done");
   endtask
   // Pauses a read after four data bits and toggles SCK while held; the byte must resume intact.
   task automatic t_hold();
      logic [3:0] hi;
      sel();
      xfer(8'h03, got);
      xfer(8'h00, got);
      xfer(8'h10, got);
      xfer(8'h00, got, 4);
      hi = got[7:4];
      @(posedge clk);
      sck <= 1'b0;
      tick(4);
      hold_b <= 1'b0;
      tick(4);
      sck <= 1'b1;
      tick(4);
      sck <= 1'b0;
      tick(4);
      check({7'h00, soOe_b}, 8'h01, "SO floats in hold");
      hold_b <= 1'b1;
      tick(4);
      xfer(8'h00, got, 4, 3);
      check({hi, got[3:0]}, 8'h4a, "read across hold");
      desel();
      $display("hold test done");
   endtask
   task automatic t_guard();
      cmd(8'h06);
      wrBytes(8'h01, 16'h0000, 8'h8c, 1);
      waitReady();
      check(st, 8'h8c, "status stored");
      cmd(8'h06);
      wrBytes(8'h02, 16'h0010, 8'h11, 1);
      waitReady();
      check(i_mem.mem[16'h10], 8'h4a, "whole array guarded");
      wp_b <= 1'b0;
      cmd(8'h06);
      wrBytes(8'h01, 16'h0000, 8'h00, 1);
      waitReady();
      check(st & 8'hfd, 8'h8c, "status locked");
      wp_b <= 1'b1;
      cmd(8'h06);
      wrBytes(8'h01, 16'h0000, 8'h04, 1);
      waitReady();
      check(st, 8'h04, "quarter guard");
      cmd(8'h06);
      wrBytes(8'h02, 16'h17ff, 8'h33, 1);
      waitReady();
      cmd(8'h06);
      wrBytes(8'h02, 16'h1800, 8'h44, 1);
      waitReady();
      check(i_mem.mem[16'h17ff], 8'h33, "below guard");
      check(i_mem.mem[16'h1800], 8'h5a, "guarded quarter");
      $display("guard test done");
   endtask
   task automatic t_unknown();
      oeSeen = 1'b0;
      sel();
      xfer(8'hff, got);
      xfer(8'h00, got);
      desel();
      check({7'h00, oeSeen}, 8'h00, "quiet after unknown");
      $display("unknown test done");
   endtask
   task automatic t_abort();
      cmd(8'h06);
      n0 = i_mem.wrCount;
      sel();
      xfer(8'h02, got);
      xfer(8'h00, got);
      xfer(8'h50, got);
      xfer(8'h77, got);
      xfer(8'h00, got, 3);
      desel();
      tick(400);
      check(8'(i_mem.wrCount - n0), 8'h00, "aborted write");
      check(i_mem.mem[16'h50], 8'h0a, "cell unchanged");
      $display("abort test done");
   endtask
   initial begin
      tick(8);
      rst_b <= 1'b1;
      tick(4);
      t_reset();
      t_latch();
      t_noLatch();
      t_page();
      t_read();
      t_hold();
      t_guard();
      t_unknown();
      t_abort();
      stop_test();
   end
endmodule // sec_eeprom_ctrl_tb
